// ===== core/ebc_bus_ctrl.sv
/*
 * External bus cycle generator: address latch, strobes, waitstates,
 * ready extension and tristate phase, per chip-select region.
 * Assumes requests are held until done; inputs synchronous to clk.
 */
`timescale 1ns/1ps
// Functional notes
// - demux normal latch: 4 half-clock units plus waits
// - demux extended latch: 6 half-clock units plus waits
// - mux normal latch: 6 half-clock units plus waits
// - mux extended latch: 8 half-clock units plus waits
// - two units per step below 15, two more if tristate field 0
// - timing picked per region from its configuration register
// - reference clock period is two half-clock units
// - read data captured on the edge ending the read strobe
// - read/write delay bit postpones strobe falling edge
// - early write bit raises write strobes earlier when ready is disabled
// - strobe phase stretched by waits or ready inactive
// - tristate wait adds a phase after the strobe
// - address and write data held until write strobe rises
// - mux: address on shared port; demux: dedicated ports plus byte enable
// - ready high adds a waitstate, low ends the cycle
// - async ready takes an extra synchroniser stage
module ebc_bus_ctrl #(
	parameter int ADDR_W = ebc_pkg::ADDR_W,
	parameter int DATA_W = ebc_pkg::DATA_W
) (
	input wire logic clk, // system clock
	input wire logic rst, // sync reset
	input wire logic [1:0] cfgSel, // region written
	input wire logic cfgLoad, // config write strobe
	input wire logic [9:0] cfgIn, // {rdy,ew,rwd,mttc,mctc[3:0],ext,mux} see below
	input wire logic req, // cycle request, held
	input wire logic reqWrite, // write when high
	input wire logic [1:0] reqRegion, // chip-select region
	input wire logic [ADDR_W-1:0] reqAddr, // address
	input wire logic [DATA_W-1:0] reqWdata, // write data
	input wire logic [1:0] reqByteEn, // byte lanes
	input wire logic readyIn, // ready pin, low = done
	input wire logic [DATA_W-1:0] sharedIn, // shared port input
	output logic [DATA_W-1:0] sharedOut, // shared port output
	output logic sharedOe_n, // shared port enable, low drives
	output logic [ADDR_W-1:0] dedAddr, // dedicated address ports
	output logic upperByteEnable_n, // upper byte enable
	output logic addrLatch, // address latch enable
	output logic readStrobe_n, // read strobe
	output logic writeStrobe_n, // full write strobe
	output logic writeLowByteStrobe_n, // low byte write
	output logic writeHighByteStrobe_n, // high byte write
	output logic writeRegionSelect_n, // write chip select
	output logic readRegionSelect_n, // read chip select
	output logic refClockOut, // reference clock out
	output logic [DATA_W-1:0] rdata, // captured read data
	output logic done // one-cycle completion pulse
);
	// config layout: [0] mux, [1] ext latch, [5:2] mctc, [6] mttc, [7] rwdelay, [8] early write,
	// [9] ready enable; async ready is always synchronised (see below)
	logic [9:0] cfgAll [ebc_pkg::REGIONS];
	genvar g;
	generate
		for (g = 0; g < ebc_pkg::REGIONS; g++) begin : gReg
			ebc_region_cfg uCfg (
				.clk(clk),
				.rst(rst),
				.cfgLoad(cfgLoad && (cfgSel == 2'(g))),
				.cfgIn(cfgIn),
				.cfgOut(cfgAll[g])
			);
		end
	endgenerate

	ebc_pkg::ebc_state_type state_q, state_d;
	logic [5:0] cnt_q, cnt_d;
	logic [9:0] cur_q;
	logic write_q;
	logic rdySync1_q, rdySync2_q;
	logic [5:0] len_q;
	logic [5:0] cycCnt_q;

	// per-region selection of the running cycle
	wire [9:0] selCfg = cfgAll[reqRegion];
	wire cMux = cur_q[0];
	wire cExt = cur_q[1];
	wire [3:0] cMctc = cur_q[5:2];
	wire cMttc = cur_q[6];
	wire cRwd = cur_q[7];
	wire cEarly = cur_q[8];
	wire cRdyEn = cur_q[9];
	// latch length taken from the region before its config is copied
	wire [1:0] latchLen = selCfg[1] ? ebc_pkg::LATCH_EXT_TCL : ebc_pkg::LATCH_NORM_TCL;
	wire [5:0] waitLen = 6'((ebc_pkg::WAIT_MAX - cMctc)) * ebc_pkg::WAIT_STEP_TCL;
	wire lastCnt = (cnt_q == 6'h01);
	// ready: two-stage synchroniser costs a waitstate
	wire rdyDone = !rdySync2_q;
	wire [3:0] baseLen = cMux ? (cExt ? ebc_pkg::BASE_MUX_EXT : ebc_pkg::BASE_MUX_NORM)
		: (cExt ? ebc_pkg::BASE_DEMUX_EXT : ebc_pkg::BASE_DEMUX_NORM);
	wire [5:0] totalLen = 6'(baseLen) + waitLen + (cMttc ? 6'h00 : 6'(ebc_pkg::FLOAT_TCL));
	wire inStrobe = (state_q == ebc_pkg::ST_STROBE) || (state_q == ebc_pkg::ST_WAIT)
		|| (state_q == ebc_pkg::ST_READY);
	// delayed falling edge: strobe absent in the first unit of the phase
	wire strobeOn = inStrobe && !(cRwd && (state_q == ebc_pkg::ST_STROBE) && (cnt_q == 6'(ebc_pkg::STROBE_TCL)));
	// early write: write strobes drop in the final unit of the phase when ready is disabled
	wire finalUnit = endStrobe && !cRdyEn;
	wire wrOn = strobeOn && write_q && !(cEarly && finalUnit);
	wire rdOn = strobeOn && !write_q;
	wire endStrobe = lastCnt && ((state_q == ebc_pkg::ST_STROBE && waitLen == 6'h00 && (!cRdyEn))
		|| (state_q == ebc_pkg::ST_WAIT && !cRdyEn) || (state_q == ebc_pkg::ST_READY && rdyDone))
		|| (state_q == ebc_pkg::ST_READY && rdyDone && cnt_q == 6'h00);

	// sequencer next state
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q != 6'h00) ? cnt_q - 6'h01 : 6'h00;
		case (state_q)
			ebc_pkg::ST_IDLE: begin
				if (req) begin
					state_d = ebc_pkg::ST_LATCH;
					cnt_d = 6'(latchLen);
				end
			end
			ebc_pkg::ST_LATCH: if (lastCnt) begin
				state_d = cMux ? ebc_pkg::ST_MUXADDR : ebc_pkg::ST_STROBE;
				cnt_d = cMux ? 6'(ebc_pkg::MUX_ADDR_TCL) : 6'(ebc_pkg::STROBE_TCL);
			end
			ebc_pkg::ST_MUXADDR: if (lastCnt) begin
				state_d = ebc_pkg::ST_STROBE;
				cnt_d = 6'(ebc_pkg::STROBE_TCL);
			end
			ebc_pkg::ST_STROBE: if (lastCnt) begin
				// stretch by memory waits, then by ready
				if (waitLen != 6'h00) begin
					state_d = ebc_pkg::ST_WAIT;
					cnt_d = waitLen;
				end else if (cRdyEn) begin
					state_d = ebc_pkg::ST_READY;
					cnt_d = 6'(ebc_pkg::STROBE_TCL);
				end else begin
					state_d = cMttc ? ebc_pkg::ST_IDLE : ebc_pkg::ST_FLOAT;
					cnt_d = cMttc ? 6'h00 : 6'(ebc_pkg::FLOAT_TCL);
				end
			end
			ebc_pkg::ST_WAIT: if (lastCnt) begin
				if (cRdyEn) begin
					state_d = ebc_pkg::ST_READY;
					cnt_d = 6'(ebc_pkg::STROBE_TCL);
				end else begin
					state_d = cMttc ? ebc_pkg::ST_IDLE : ebc_pkg::ST_FLOAT;
					cnt_d = cMttc ? 6'h00 : 6'(ebc_pkg::FLOAT_TCL);
				end
			end
			ebc_pkg::ST_READY: begin
				// sample at each reference period end: high waits, low ends
				if (lastCnt || cnt_q == 6'h00) begin
					if (rdyDone) begin
						state_d = cMttc ? ebc_pkg::ST_IDLE : ebc_pkg::ST_FLOAT;
						cnt_d = cMttc ? 6'h00 : 6'(ebc_pkg::FLOAT_TCL);
					end else begin
						cnt_d = 6'(ebc_pkg::HALF_UNITS_PER_REF);
					end
				end
			end
			ebc_pkg::ST_FLOAT: if (lastCnt) begin
				state_d = ebc_pkg::ST_IDLE; // tristate phase
			end
			default: begin
				state_d = ebc_pkg::ST_IDLE;
				cnt_d = 6'h00;
			end
		endcase
	end

	// state, captured config and ready synchroniser
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ebc_pkg::ST_IDLE;
			cnt_q <= 6'h00;
			cur_q <= 10'h000;
			write_q <= 1'b0;
			rdySync1_q <= 1'b1;
			rdySync2_q <= 1'b1;
			len_q <= 6'h00;
			cycCnt_q <= 6'h00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			rdySync1_q <= readyIn;
			rdySync2_q <= rdySync1_q;
			if (state_q == ebc_pkg::ST_IDLE && req) begin
				cur_q <= selCfg;
				write_q <= reqWrite;
			end
			if (state_q == ebc_pkg::ST_LATCH) begin
				len_q <= totalLen;
			end
			// clocks since the taking edge; wraps only in ready-held cycles
			if (state_q == ebc_pkg::ST_IDLE && req) begin
				cycCnt_q <= 6'h01;
			end else if (state_q != ebc_pkg::ST_IDLE) begin
				cycCnt_q <= cycCnt_q + 6'h01;
			end
		end
	end

	// reference clock toggles each half-clock unit, so period is two units
	always_ff @(posedge clk) begin
		if (rst) begin
			refClockOut <= 1'b0;
		end else begin
			refClockOut <= !refClockOut;
		end
	end

	// pins registered; address held through the whole cycle incl. strobe rise
	wire busy = (state_d != ebc_pkg::ST_IDLE) && (state_d != ebc_pkg::ST_FLOAT);
	// at the taking edge the copied config is not there yet, so look at the region
	wire curMux = (state_q == ebc_pkg::ST_IDLE) ? selCfg[0] : cMux;
	wire muxAddrPhase = curMux && (state_q == ebc_pkg::ST_LATCH || (state_q == ebc_pkg::ST_IDLE && req));
	always_ff @(posedge clk) begin
		if (rst) begin
			sharedOut <= '0;
			sharedOe_n <= 1'b1;
			dedAddr <= '0;
			upperByteEnable_n <= 1'b1;
			addrLatch <= 1'b0;
			readStrobe_n <= 1'b1;
			writeStrobe_n <= 1'b1;
			writeLowByteStrobe_n <= 1'b1;
			writeHighByteStrobe_n <= 1'b1;
			writeRegionSelect_n <= 1'b1;
			readRegionSelect_n <= 1'b1;
			rdata <= '0;
			done <= 1'b0;
		end else begin
			addrLatch <= (state_d == ebc_pkg::ST_LATCH);
			if (busy) begin
				dedAddr <= reqAddr;
				upperByteEnable_n <= !reqByteEn[1];
			end
			// shared port: address in mux latch phase, write data later
			sharedOut <= (muxAddrPhase && state_d == ebc_pkg::ST_LATCH) ? DATA_W'(reqAddr) : reqWdata;
			// write data stays driven until the write strobe has risen
			sharedOe_n <= !((busy && ((curMux && state_d == ebc_pkg::ST_LATCH) || reqWrite)) || wrOn);
			readStrobe_n <= !rdOn;
			readRegionSelect_n <= !rdOn;
			writeStrobe_n <= !wrOn;
			writeRegionSelect_n <= !wrOn;
			writeLowByteStrobe_n <= !(wrOn && reqByteEn[0]);
			writeHighByteStrobe_n <= !(wrOn && reqByteEn[1]);
			// capture on the very edge that raises the read strobe pin
			if (!readStrobe_n && !rdOn) begin
				rdata <= sharedIn;
			end
			done <= (state_q != ebc_pkg::ST_IDLE) && (state_d == ebc_pkg::ST_IDLE);
		end
	end

	// demux normal cycle length ties to base when no waits, no tristate phase and ready unused
	sequence cycStart;
		state_q == ebc_pkg::ST_IDLE && req;
	endsequence
	cyc_len_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == ebc_pkg::ST_LATCH && $past(state_q) == ebc_pkg::ST_IDLE && !cRdyEn && !cMux && !cExt
		&& cMctc == 4'hF && cMttc) |-> ##3 done)
		else $error("demux normal cycle length wrong");
	rd_cap_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) && $rose(readStrobe_n) |-> rdata == $past(sharedIn))
		else $error("read data not captured at strobe end");
	ref_clk_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) |-> refClockOut != $past(refClockOut))
		else $error("reference clock period not two units");
	wr_hold_a: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) && $rose(writeStrobe_n) |-> $stable(dedAddr))
		else $error("address changed at write strobe rise");
	rdy_wait_a: assert property (@(posedge clk) disable iff (rst)
		state_q == ebc_pkg::ST_READY && rdySync2_q && cnt_q == 6'h00 |=> state_q == ebc_pkg::ST_READY)
		else $error("ready high did not extend cycle");
	float_a: assert property (@(posedge clk) disable iff (rst)
		state_q == ebc_pkg::ST_FLOAT |-> !cMttc)
		else $error("tristate phase without selection");
	start_a: assert property (@(posedge clk) disable iff (rst)
		cycStart |=> cur_q == $past(selCfg))
		else $error("region config not taken");
	no_both_a: assert property (@(posedge clk) disable iff (rst)
		!(!readStrobe_n && !writeStrobe_n))
		else $error("read and write strobes together");
	// every cycle without ready lasts exactly its configured total
	cyc_total_a: assert property (@(posedge clk) disable iff (rst)
		done && !cRdyEn |-> cycCnt_q == len_q)
		else $error("cycle length differs from its configured total");
endmodule // ebc_bus_ctrl

// ===== core/ebc_pkg.sv
/*
 * Constants of the external bus cycle controller: phase counts in
 * half-clock units, field widths, region count and reset values.
 * Assumes a single 50 MHz clock; one half-clock unit is one clk cycle.
 */
package ebc_pkg;
	localparam int REGIONS = 4;
	localparam int REGION_W = 2;
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int WAIT_W = 4;
	localparam logic [3:0] WAIT_MAX = 4'hF;
	// base durations in half-clock units
	localparam logic [3:0] BASE_DEMUX_NORM = 4'h4;
	localparam logic [3:0] BASE_DEMUX_EXT = 4'h6;
	localparam logic [3:0] BASE_MUX_NORM = 4'h6;
	localparam logic [3:0] BASE_MUX_EXT = 4'h8;
	localparam logic [1:0] LATCH_NORM_TCL = 2'h1;
	localparam logic [1:0] LATCH_EXT_TCL = 2'h3;
	localparam logic [1:0] MUX_ADDR_TCL = 2'h2;
	localparam logic [5:0] WAIT_STEP_TCL = 6'h02;
	localparam logic [1:0] FLOAT_TCL = 2'h2;
	localparam logic [1:0] STROBE_TCL = 2'h2;
	localparam logic [1:0] HALF_UNITS_PER_REF = 2'h2;
	localparam logic [5:0] CFG_RESET = 6'h00;
	typedef enum logic [2:0] {ST_IDLE, ST_LATCH, ST_MUXADDR, ST_STROBE, ST_WAIT, ST_READY, ST_FLOAT} ebc_state_type;
endpackage

// ===== core/ebc_region_cfg.sv
/*
 * One region's bus configuration register: address-latch mode, mux mode,
 * memory-cycle wait, tristate wait, read/write delay and early write.
 * Assumes the loader holds cfgLoad for one clock per write.
 */
`timescale 1ns/1ps
module ebc_region_cfg (
	input wire logic clk, // system clock
	input wire logic rst, // sync reset
	input wire logic cfgLoad, // write strobe
	input wire logic [9:0] cfgIn, // new value
	output logic [9:0] cfgOut // held value
);
	// holds settings of this region
	always_ff @(posedge clk) begin
		if (rst) begin
			cfgOut <= 10'h000;
		end else if (cfgLoad) begin
			cfgOut <= cfgIn;
		end
	end
endmodule // ebc_region_cfg

// ===== verif/ebc_mem_model.sv
/*
 * Behavioural memory on the far side of the bus: answers reads from its
 * latched address and drives ready. Assumes the bench tells it the mux mode.
 */
`timescale 1ns/1ps
module ebc_mem_model (
	input wire logic clk, // system clock
	input wire logic mux, // region in mux mode
	input wire logic [7:0] readyDelay, // not-ready strobe cycles
	input wire logic addrLatch, // latch phase
	input wire logic [15:0] sharedOut, // shared port from block
	input wire logic [23:0] dedAddr, // dedicated address
	input wire logic readStrobe_n, // read strobe
	input wire logic writeStrobe_n, // write strobe
	output logic [15:0] sharedIn, // read data to block
	output logic readyIn // ready, low ends cycle
);
	logic [15:0] addr_q;
	logic [15:0] float_q;
	logic [7:0] cnt_q;
	logic idle;
	assign idle = readStrobe_n && writeStrobe_n;
	// data follows the strobe like an async memory, so it stands at the rising edge
	assign sharedIn = !readStrobe_n ? (addr_q ^ 16'hA5C3) : float_q;
	initial begin
		addr_q = 16'h0000;
		float_q = 16'h0000;
		cnt_q = 8'h00;
		readyIn = 1'b1;
	end
	// address taken from the shared port in mux mode, else the dedicated one
	always @(posedge clk) begin
		if (addrLatch) addr_q <= mux ? sharedOut : dedAddr[15:0];
		cnt_q <= idle ? 8'h00 : cnt_q + 8'h01;
		// released port toggles so a stale value never looks valid
		float_q <= ~float_q;
		readyIn <= idle || (cnt_q < readyDelay);
	end
endmodule // ebc_mem_model

// ===== verif/external_bus_cycle_control_tb_top.sv
/*
 * Self-checking bench of the bus cycle generator: table of cycle kinds,
 * then reset, region, back-to-back and ready cases. Assumes ebc_mem_model.
 */
`timescale 1ns/1ps
module external_bus_cycle_control_tb_top;
	typedef struct packed {
		logic [9:0] cfg; // configuration
		logic wr; // write access
		logic [1:0] be; // byte lanes
	} ebc_row_type;
	logic clk, rst, cfgLoad, req, reqWrite, readyIn, muxMode, sharedOe_n, upperByteEnable_n, addrLatch;
	logic readStrobe_n, writeStrobe_n, writeLowByteStrobe_n, writeHighByteStrobe_n, writeRegionSelect_n;
	logic refClockOut, done, readRegionSelect_n;
	logic [1:0] cfgSel, reqRegion, reqByteEn;
	logic [9:0] cfgIn;
	logic [23:0] reqAddr, dedAddr, a;
	logic [15:0] reqWdata, sharedIn, sharedOut, rdata, d;
	logic [7:0] readyDelay;
	int num_errors = 0, cmp_count = 0, lat, s, w;
	int cnt [6];
	ebc_row_type r;
	ebc_row_type rows [10] = '{'{10'h07C, 1'h0, 2'h3}, '{10'h07E, 1'h1, 2'h3}, '{10'h07D, 1'h0, 2'h3},
		'{10'h07F, 1'h1, 2'h1}, '{10'h038, 1'h0, 2'h3}, '{10'h041, 1'h1, 2'h2}, '{10'h0FC, 1'h0, 2'h3},
		'{10'h0FC, 1'h1, 2'h3}, '{10'h17C, 1'h1, 2'h3}, '{10'h1FD, 1'h1, 2'h3}};

	ebc_bus_ctrl i_dut (.clk(clk), .rst(rst), .cfgSel(cfgSel), .cfgLoad(cfgLoad), .cfgIn(cfgIn), .req(req),
		.reqWrite(reqWrite), .reqRegion(reqRegion), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqByteEn(reqByteEn),
		.readyIn(readyIn), .sharedIn(sharedIn), .sharedOut(sharedOut), .sharedOe_n(sharedOe_n), .dedAddr(dedAddr),
		.upperByteEnable_n(upperByteEnable_n), .addrLatch(addrLatch), .readStrobe_n(readStrobe_n),
		.writeStrobe_n(writeStrobe_n), .writeLowByteStrobe_n(writeLowByteStrobe_n),
		.writeHighByteStrobe_n(writeHighByteStrobe_n), .writeRegionSelect_n(writeRegionSelect_n),
		.readRegionSelect_n(readRegionSelect_n), .refClockOut(refClockOut), .rdata(rdata), .done(done));
	ebc_mem_model i_mem (.clk(clk), .mux(muxMode), .readyDelay(readyDelay), .addrLatch(addrLatch),
		.sharedOut(sharedOut), .dedAddr(dedAddr), .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
		.sharedIn(sharedIn), .readyIn(readyIn));

	// expected length in clocks from the taking edge to done
	function automatic int exp_lat(input logic [9:0] c);
		return 4 + 2 * c[1] + 2 * c[0] + 2 * (15 - c[5:2]) + 2 * (1 - c[6]);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("checks %0d, errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic load(input logic [1:0] rg, input logic [9:0] v);
		@(posedge clk) cfgSel <= rg;
		cfgIn <= v;
		cfgLoad <= 1'b1;
		@(posedge clk) cfgLoad <= 1'b0;
		#1;
	endtask
	// one cycle; counts strobe clocks and bus-value slips while it runs
	task automatic run(input logic [1:0] rg, input logic wr, input logic [15:0] dd, input logic [1:0] be, input logic keep);
		logic pr;
		logic strobe;
		pr = refClockOut;
		lat = 0;
		cnt = '{default: 0};
		reqRegion <= rg;
		reqWrite <= wr;
		reqAddr <= a;
		reqWdata <= dd;
		reqByteEn <= be;
		req <= 1'b1;
		do begin
			@(posedge clk);
			#1;
			lat++;
			strobe = readStrobe_n === 1'b0 || writeStrobe_n === 1'b0;
			cnt[0] += readStrobe_n === 1'b0;
			cnt[1] += writeStrobe_n === 1'b0;
			cnt[2] += writeLowByteStrobe_n === 1'b0;
			cnt[3] += writeHighByteStrobe_n === 1'b0;
			cnt[4] += writeRegionSelect_n === 1'b0;
			cnt[5] += refClockOut === pr;
			cnt[5] += addrLatch === 1'b1 && muxMode && (sharedOut !== a[15:0] || sharedOe_n !== 1'b0);
			cnt[5] += strobe && !muxMode && (dedAddr !== a || upperByteEnable_n !== ~be[1]);
			cnt[5] += strobe && wr && (sharedOut !== dd || sharedOe_n !== 1'b0);
			cnt[5] += readRegionSelect_n !== readStrobe_n;
			pr = refClockOut;
		end while (done !== 1'b1 && lat < 300);
		if (!keep) begin
			req <= 1'b0;
			// read data lands at the strobe's rising edge, at most one clock after done
			@(posedge clk);
			#1;
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// hang guard, well past the few hundred clocks the run needs
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
	initial begin
		{rst, cfgLoad, req, reqWrite, muxMode} = 5'h10;
		{cfgSel, reqRegion, reqByteEn, cfgIn, reqAddr, reqWdata, readyDelay, a} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("idle outputs", {readStrobe_n, writeStrobe_n, sharedOe_n, addrLatch, done}, 5'h1C);
		a = 24'h000ABC;
		run(2'h3, 1'b0, 16'h0000, 2'h3, 1'b0);
		chk("reset config length", lat, exp_lat(10'h000));
		for (int i = 0; i < 10; i++) begin
			r = rows[i];
			a = 24'h3C1200 + 24'(i * 273);
			d = 16'h5A00 + 16'(i);
			muxMode = r.cfg[0];
			load(2'(i), r.cfg);
			run(2'(i), r.wr, d, r.be, 1'b0);
			s = 2 + 2 * (15 - r.cfg[5:2]) - r.cfg[7];
			w = r.wr ? s - (r.cfg[8] && !r.cfg[9]) : 0;
			chk("cycle length", lat, exp_lat(r.cfg));
			chk("read strobe clocks", cnt[0], r.wr ? 0 : s);
			chk("write strobe clocks", cnt[1], w);
			chk("low byte strobe clocks", cnt[2], r.be[0] ? w : 0);
			chk("high byte strobe clocks", cnt[3], r.be[1] ? w : 0);
			chk("write select clocks", cnt[4], w);
			chk("bus value slips", cnt[5], 0);
			if (!r.wr) chk("read data", rdata, a[15:0] ^ 16'hA5C3);
		end
		// region 1 rewritten must not disturb region 0; then back to back
		load(2'h1, 10'h07F);
		muxMode = 1'b0;
		run(2'h0, 1'b1, 16'h1234, 2'h3, 1'b1);
		run(2'h0, 1'b0, 16'h0000, 2'h3, 1'b0);
		chk("region length", lat, exp_lat(10'h17C));
		chk("read data", rdata, a[15:0] ^ 16'hA5C3);
		load(2'h2, 10'h27C);
		run(2'h2, 1'b0, 16'h0000, 2'h3, 1'b0);
		chk("ready min length", lat >= exp_lat(10'h27C) + 2, 1'b1);
		readyDelay = 8'h0C;
		run(2'h2, 1'b0, 16'h0000, 2'h3, 1'b0);
		chk("ready held length", lat >= exp_lat(10'h27C) + 10 && lat <= exp_lat(10'h27C) + 20, 1'b1);
		// reset in mid-cycle drops every strobe and the configs
		@(posedge clk) req <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		req <= 1'b0;
		#1;
		chk("idle after reset", {readStrobe_n, writeStrobe_n, sharedOe_n, addrLatch, done}, 5'h1C);
		run(2'h2, 1'b0, 16'h0000, 2'h3, 1'b0);
		chk("config after reset", lat, exp_lat(10'h000));
		summarize();
	end
endmodule // external_bus_cycle_control_tb_top
